/* File: rtl/reset_strap_map.vh */
// Purpose: offsets, field positions, reset values and timing counts for reset_strap_clock_control
// Assumes: 20 MHz register clock, 32-bit classic Wishbone slave
// Notes: definitions only
`ifndef RESET_STRAP_MAP_VH
`define RESET_STRAP_MAP_VH

// register byte offsets
`define RSC_ADDR_STATUS 8'h00
`define RSC_ADDR_CLKCTL 8'h04
`define RSC_ADDR_WDOG 8'h08

// clock and bus control fields
`define RSC_CLK_MULT_LSB 0
`define RSC_CLK_MULT_W 3
`define RSC_CLK_MULT_RST 3'h4
`define RSC_CLK_MULT_MAX 3'h5

// watchdog control fields
`define RSC_WDOG_EXPIRE_BIT 0

// status fields
`define RSC_ST_WIDTH_LSB 0
`define RSC_ST_POL_BIT 2
`define RSC_ST_CLKSRC_BIT 3
`define RSC_ST_SYSRST_BIT 4
`define RSC_ST_WDOG_BIT 5

// boot bank width codes
`define RSC_WIDTH_RSVD 2'h0
`define RSC_WIDTH_BYTE 2'h1
`define RSC_WIDTH_HALF 2'h2
`define RSC_WIDTH_WORD 2'h3

// timing
`define RSC_CLK_HZ 20000000
`define RSC_SYSRST_MS 200
`define RSC_SYSRST_CYC ((`RSC_CLK_HZ / 1000) * `RSC_SYSRST_MS)
`define RSC_CHIPRST_CYC 256

`endif

/* File: rtl/sync_2ff.v */
// Purpose: two-flop synchroniser for one level
// Assumes: input is asynchronous to clk_i
// Notes: first flop feeds only the second
`timescale 1ns/10ps
module sync_2ff #(
    parameter RESET_VAL = 1'b0
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // data
    input wire d_i,
    output wire q_o
);
    reg meta_q;
    reg sync_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else if (ce_i) begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule // sync_2ff

/* File: rtl/pulse_stretch.v */
// Purpose: holds an output for a minimum number of cycles after a trigger ends
// Assumes: trigger is synchronous to clk_i
// Notes: retriggers while trigger stays high
`timescale 1ns/10ps
module pulse_stretch #(
    parameter CNT_W = 23,
    parameter HOLD_CYC = 4000000
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // trigger and output
    input wire trig_i,
    output wire active_o
);
    reg [CNT_W-1:0] cnt_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= {CNT_W{1'b0}};
        end else if (ce_i) begin
            if (trig_i) begin
                cnt_q <= HOLD_CYC[CNT_W-1:0];
            end else if (cnt_q != {CNT_W{1'b0}}) begin
                cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign active_o = trig_i | (cnt_q != {CNT_W{1'b0}});
endmodule // pulse_stretch

/* File: rtl/reset_strap_clock_control.v */
// Purpose: chip reset, strap capture, system reset output and clock select control
// Assumes: clk_i is the 20 MHz register clock; pins are asynchronous and synchronised here
// Notes: SYSRST_CYC sets the reset-out stretch, 200 ms at 20 MHz by default
//        registers: 0x00 status, 0x04 clock and bus control, 0x08 watchdog trigger
//        straps reach the logic through synchronisers, so the kept copy lags the pins
//        ce_i low freezes every flop, the synchronisers included
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/10ps
`include "reset_strap_map.vh"
module reset_strap_clock_control #(
    parameter SYSRST_CYC = `RSC_SYSRST_CYC,
    parameter CNT_W = 23
) (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // chip reset pin
    input wire chip_reset_n_i,
    // shared strap / function pins
    input wire [1:0] boot_bank_width_strap_i,
    input wire reset_out_polarity_strap_i,
    input wire cpu_clock_source_strap_i,
    input wire ext_output_enable_n_func_i,
    input wire uart_request_to_send_n_func_i,
    input wire [1:0] wan_indicator_func_i,
    output reg ext_output_enable_n_o,
    output reg ext_output_enable_n_oe_n_o,
    output reg uart_request_to_send_n_o,
    output reg uart_request_to_send_n_oe_n_o,
    output reg [1:0] wan_indicator_o,
    output reg [1:0] wan_indicator_oe_n_o,
    // system reset out pin
    output reg system_reset_out_o,
    output reg system_reset_out_oe_n_o,
    // internal reset and boot configuration
    output reg core_reset_o,
    output reg [1:0] boot_bank_width_o,
    output reg boot_width_valid_o,
    // clock control
    output reg cpu_clk_sel_ext_o,
    output reg [2:0] pll_mult_o,
    output reg ref_clk_to_phy_o
);
    // synchronised pins
    wire chip_reset_n_s;
    wire [1:0] width_s;
    wire pol_s;
    wire clksrc_s;

    // note: pins start in reset, so sync resets to asserted chip reset
    sync_2ff #(.RESET_VAL(1'b0)) u_sync_rst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(chip_reset_n_i),
        .q_o(chip_reset_n_s)
    );
    sync_2ff #(.RESET_VAL(1'b0)) u_sync_w0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(boot_bank_width_strap_i[0]),
        .q_o(width_s[0])
    );
    sync_2ff #(.RESET_VAL(1'b0)) u_sync_w1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(boot_bank_width_strap_i[1]),
        .q_o(width_s[1])
    );
    sync_2ff #(.RESET_VAL(1'b0)) u_sync_pol (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(reset_out_polarity_strap_i),
        .q_o(pol_s)
    );
    sync_2ff #(.RESET_VAL(1'b0)) u_sync_clk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(cpu_clock_source_strap_i),
        .q_o(clksrc_s)
    );

    // state
    localparam ST_RESET = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_WDOG = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [1:0] width_q;
    reg pol_q;
    reg clksrc_q;
    reg wdog_q;
    reg wdog_seen_q;
    reg [2:0] mult_q;
    reg in_reset_q;
    wire chip_rst;
    wire sysrst_active;

    assign chip_rst = ~chip_reset_n_s;

    // pins float from the first synchronised reset edge until the machine leaves reset
    wire pins_float;
    assign pins_float = chip_rst | (state_q == ST_RESET);
    // active level follows the kept polarity strap
    wire sysrst_level;
    assign sysrst_level = pol_q ? ~sysrst_active : sysrst_active;
    wire stretch_trig;
    assign stretch_trig = chip_rst | wdog_q;

    pulse_stretch #(.CNT_W(CNT_W), .HOLD_CYC(SYSRST_CYC)) u_stretch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .trig_i(stretch_trig),
        .active_o(sysrst_active)
    );

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RESET: begin
                if (!chip_rst) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (chip_rst) begin
                    state_d = ST_RESET;
                end else if (wdog_q) begin
                    state_d = ST_WDOG;
                end
            end
            ST_WDOG: begin
                if (!sysrst_active && chip_rst) begin
                    state_d = ST_RESET;
                end else if (!sysrst_active) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_RESET;
            width_q <= `RSC_WIDTH_RSVD;
            pol_q <= 1'b0;
            clksrc_q <= 1'b0;
            in_reset_q <= 1'b1;
        end else if (ce_i) begin
            state_q <= state_d;
            in_reset_q <= (state_d != ST_RUN);
            // sample straps while chip reset held
            // last sample before release is kept
            if (chip_rst) begin
                width_q <= width_s;
                pol_q <= pol_s;
                clksrc_q <= clksrc_s;
            end
        end
    end

    // wishbone slave: one wait state, ack drops after one cycle
    wire wb_req;
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // writes clamp to multiples 1..5, so the clock stays within 25..125 MHz
    reg [2:0] mult_wr;
    always @* begin
        mult_wr = wb_dat_i[2:0];
        if (wb_dat_i[2:0] > `RSC_CLK_MULT_MAX) begin
            mult_wr = `RSC_CLK_MULT_MAX;
        end else if (wb_dat_i[2:0] == 3'h0) begin
            mult_wr = 3'h1;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            mult_q <= `RSC_CLK_MULT_RST;
            wdog_q <= 1'b0;
            wdog_seen_q <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            wdog_q <= 1'b0;
            if (state_q == ST_RESET) begin
                mult_q <= `RSC_CLK_MULT_RST;
                wdog_seen_q <= 1'b0;
            end
            if (state_q == ST_WDOG) begin
                wdog_seen_q <= 1'b1;
            end
            if (wb_req) begin
                wb_dat_o <= 32'h0;
                case (wb_adr_i)
                    `RSC_ADDR_STATUS: begin
                        wb_dat_o <= {26'h0, wdog_seen_q, in_reset_q, clksrc_q, pol_q, width_q};
                    end
                    `RSC_ADDR_CLKCTL: begin
                        wb_dat_o <= {29'h0, mult_q};
                        if (wb_we_i && wb_sel_i[0] && state_q == ST_RUN) begin
                            mult_q <= mult_wr;
                        end
                    end
                    `RSC_ADDR_WDOG: begin
                        // expiry event from a bus write with bit 0 set, taken only in run
                        if (wb_we_i && wb_sel_i[0] && wb_dat_i[`RSC_WDOG_EXPIRE_BIT]
                                && state_q == ST_RUN) begin
                            wdog_q <= 1'b1;
                        end
                    end
                    default: begin
                        wb_dat_o <= 32'h0;
                    end
                endcase
            end
        end
    end

    // outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            ext_output_enable_n_o <= 1'b1;
            ext_output_enable_n_oe_n_o <= 1'b1;
            uart_request_to_send_n_o <= 1'b1;
            uart_request_to_send_n_oe_n_o <= 1'b1;
            wan_indicator_o <= 2'h0;
            wan_indicator_oe_n_o <= 2'h3;
            system_reset_out_o <= 1'b0;
            system_reset_out_oe_n_o <= 1'b1;
            core_reset_o <= 1'b1;
            boot_bank_width_o <= `RSC_WIDTH_RSVD;
            boot_width_valid_o <= 1'b0;
            cpu_clk_sel_ext_o <= 1'b0;
            pll_mult_o <= `RSC_CLK_MULT_RST;
            ref_clk_to_phy_o <= 1'b0;
        end else if (ce_i) begin
            // float the function pins during chip reset
            ext_output_enable_n_o <= ext_output_enable_n_func_i;
            ext_output_enable_n_oe_n_o <= pins_float;
            uart_request_to_send_n_o <= uart_request_to_send_n_func_i;
            uart_request_to_send_n_oe_n_o <= pins_float;
            wan_indicator_o <= wan_indicator_func_i;
            wan_indicator_oe_n_o <= {2{pins_float}};
            // reset out is the one pin driven while chip reset holds
            system_reset_out_o <= sysrst_level;
            system_reset_out_oe_n_o <= 1'b0;
            // internal reset for chip reset and watchdog
            core_reset_o <= (state_d != ST_RUN);
            // code passed through, 00 flagged invalid
            boot_bank_width_o <= width_q;
            boot_width_valid_o <= (width_q != `RSC_WIDTH_RSVD);
            cpu_clk_sel_ext_o <= clksrc_q;
            // multiple of 25 MHz, 1..5 becomes 25..125 MHz
            pll_mult_o <= mult_q;
            ref_clk_to_phy_o <= ~in_reset_q;
        end
    end
endmodule // reset_strap_clock_control

/* File: dv/rsc_chk_assertions.sv */
// Purpose: port checks for reset_strap_clock_control
// Assumes: straps stay steady through chip reset
// Notes: strap copies are taken while the reset pin is low
`timescale 1ns/10ps
module rsc_chk #(
    parameter SYSRST_CYC = 20
) (
    // clock, reset, bus
    input logic clk_i,
    input logic rst_i,
    input logic wb_we_i,
    input logic [7:0] wb_adr_i,
    input logic [31:0] wb_dat_i,
    input logic wb_ack_o,
    // pins
    input logic chip_reset_n_i,
    input logic [1:0] boot_bank_width_strap_i,
    input logic reset_out_polarity_strap_i,
    input logic cpu_clock_source_strap_i,
    input logic ext_output_enable_n_oe_n_o,
    input logic uart_request_to_send_n_oe_n_o,
    input logic [1:0] wan_indicator_oe_n_o,
    input logic system_reset_out_o,
    // internal
    input logic core_reset_o,
    input logic [1:0] boot_bank_width_o,
    input logic cpu_clk_sel_ext_o,
    input logic [2:0] pll_mult_o
);
    logic [3:0] cfg_q;
    int hold_q;
    wire [3:0] oe_n = {ext_output_enable_n_oe_n_o, uart_request_to_send_n_oe_n_o,
        wan_indicator_oe_n_o};
    wire run = !core_reset_o && system_reset_out_o == cfg_q[2];
    wire wr = wb_ack_o && wb_we_i && run;
    wire wd = wr && wb_adr_i == 8'h08 && wb_dat_i[0];
    wire [2:0] dv = wb_dat_i[2:0];
    wire [2:0] mul = dv == 3'h0 ? 3'h1 : (dv > 3'h5 ? 3'h5 : dv);
    // hold_q counts the shortest stretch the reset output may have after release
    always_ff @(posedge clk_i) begin
        if (!chip_reset_n_i) begin
            cfg_q <= {cpu_clock_source_strap_i, reset_out_polarity_strap_i,
                boot_bank_width_strap_i};
        end
        if (rst_i) begin
            hold_q <= 0;
        end else if (!chip_reset_n_i) begin
            hold_q <= SYSRST_CYC;
        end else if (hold_q != 0) begin
            hold_q <= hold_q - 1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_float; (!chip_reset_n_i) [*8] |-> oe_n == 4'hf && core_reset_o; endproperty
    a_float: assert property (p_float) else $error("pins not floating");
    property p_on; (!chip_reset_n_i) [*8] |-> system_reset_out_o == !cfg_q[2]; endproperty
    a_on: assert property (p_on) else $error("reset out not active");
    property p_hold; hold_q != 0 && chip_reset_n_i |-> system_reset_out_o != cfg_q[2]; endproperty
    a_hold: assert property (p_hold) else $error("reset out too short");
    property p_wdc; wd |-> ##[1:3] core_reset_o; endproperty
    a_wdc: assert property (p_wdc) else $error("no internal reset");
    property p_wdo; wd |-> ##[1:3] system_reset_out_o != cfg_q[2]; endproperty
    a_wdo: assert property (p_wdo) else $error("no reset out");
    property p_cfg; chip_reset_n_i [*6] |-> boot_bank_width_o == cfg_q[1:0]
        && cpu_clk_sel_ext_o == cfg_q[3]; endproperty
    a_cfg: assert property (p_cfg) else $error("strap copy wrong");
    property p_pins; (chip_reset_n_i && !core_reset_o) [*6] |-> oe_n == 4'h0; endproperty
    a_pins: assert property (p_pins) else $error("pins not driven");
    property p_mult; wr && wb_adr_i == 8'h04 |=> pll_mult_o == $past(mul); endproperty
    a_mult: assert property (p_mult) else $error("multiplier wrong");
    property p_boot; $fell(core_reset_o) |-> boot_bank_width_o == cfg_q[1:0]; endproperty
    a_boot: assert property (p_boot) else $error("boot width late");
endmodule // rsc_chk

bind reset_strap_clock_control rsc_chk #(.SYSRST_CYC(SYSRST_CYC)) u_chk (
    .clk_i, .rst_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .chip_reset_n_i,
    .boot_bank_width_strap_i, .reset_out_polarity_strap_i, .cpu_clock_source_strap_i,
    .ext_output_enable_n_oe_n_o, .uart_request_to_send_n_oe_n_o, .wan_indicator_oe_n_o,
    .system_reset_out_o, .core_reset_o, .boot_bank_width_o, .cpu_clk_sel_ext_o,
    .pll_mult_o);

/* File: dv/board_rst.sv */
// Purpose: board reset circuit for the reset pin and the straps
// Assumes: go_i asks for one reset; cfg_i is {clock source, polarity, width}
// Notes: released strap lines toggle so a late sample is caught
`timescale 1ns/10ps
module board_rst (
    // clock and request
    input logic clk_i,
    input logic go_i,
    input logic [3:0] cfg_i,
    // board pins
    output logic chip_reset_n_o,
    output logic [3:0] strap_o
);
    logic [8:0] cnt_q = 9'h108;
    assign chip_reset_n_o = cnt_q < 9'h005;
    always @(posedge clk_i) begin
        if (go_i) begin
            cnt_q <= 9'h108;
        end else if (cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
        end
    end
    always @(posedge clk_i) begin
        if (go_i || cnt_q != 9'h000) begin
            strap_o <= cfg_i;
        end else begin
            strap_o <= ~strap_o;
        end
    end
endmodule // board_rst

/* File: dv/reset_strap_clock_control_tb.sv */
// Purpose: self-checking bench for reset_strap_clock_control
// Assumes: reset output hold shortened to SYS cycles
// Notes: the board model owns the reset pin and straps
`timescale 1ns/10ps
`include "reset_strap_map.vh"
module reset_strap_clock_control_tb;
    localparam int SYS = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic go = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0] cfg = 4'h3;
    logic [3:0] fn = 4'h3;
    logic [31:0] rd, rdat;
    logic [3:0] strap;
    logic [1:0] bw, wan, woe;
    logic [2:0] mult;
    logic ack, rstn, eo, eoe, uo, uoe, sro, soe, core, valid, csel, refo;
    int bad_count = 0;
    int cmp_count = 0;
    always #25 clk_i = ~clk_i;
    reset_strap_clock_control #(.SYSRST_CYC(SYS)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .chip_reset_n_i(rstn), .boot_bank_width_strap_i(strap[1:0]),
        .reset_out_polarity_strap_i(strap[2]), .cpu_clock_source_strap_i(strap[3]),
        .ext_output_enable_n_func_i(fn[0]), .uart_request_to_send_n_func_i(fn[1]),
        .wan_indicator_func_i(fn[3:2]), .ext_output_enable_n_o(eo),
        .ext_output_enable_n_oe_n_o(eoe), .uart_request_to_send_n_o(uo),
        .uart_request_to_send_n_oe_n_o(uoe), .wan_indicator_o(wan),
        .wan_indicator_oe_n_o(woe), .system_reset_out_o(sro), .system_reset_out_oe_n_o(soe),
        .core_reset_o(core), .boot_bank_width_o(bw), .boot_width_valid_o(valid),
        .cpu_clk_sel_ext_o(csel), .pll_mult_o(mult), .ref_clk_to_phy_o(refo));
    board_rst board (.clk_i(clk_i), .go_i(go), .cfg_i(cfg), .chip_reset_n_o(rstn),
        .strap_o(strap));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0;
        if (n >= 20) chk("ack", 1, 0);
    endtask
    task automatic wait_up();
        int n;
        n = 0;
        while (rstn !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        repeat (SYS) @(posedge clk_i);
    endtask
    task automatic t_boot(input logic [3:0] c);
        @(posedge clk_i);
        cfg <= c;
        fn <= c;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (12) @(posedge clk_i);
        chk("float", 4'hf, {eoe, uoe, woe});
        chk("rst on", !c[2], sro);
        wait_up();
        chk("rst held", !c[2], sro);
        repeat (8) @(posedge clk_i);
        chk("rst off", c[2], sro);
        chk("rst oe", 0, soe);
        chk("width", c[1:0], bw);
        chk("valid", c[1:0] != 2'h0, valid);
        chk("clksrc", c[3], csel);
        chk("ref", 1, refo);
        chk("drive", 0, {eoe, uoe, woe});
        chk("pins", c, {wan, uo, eo});
        wb(0, `RSC_ADDR_STATUS, 0);
        chk("status", c, rd[3:0]);
        $display("test boot %h done", c);
    endtask
    task automatic t_regs();
        logic [2:0] e;
        wb(0, `RSC_ADDR_CLKCTL, 0);
        chk("mult rst", `RSC_CLK_MULT_RST, rd[2:0]);
        for (int i = 0; i < 8; i++) begin
            e = i == 0 ? 3'h1 : (i > 5 ? 3'h5 : 3'(i));
            wb(1, `RSC_ADDR_CLKCTL, i);
            wb(0, `RSC_ADDR_CLKCTL, 0);
            chk("clkctl", e, rd[2:0]);
            chk("mult", e, mult);
        end
        wb(1, 8'h0c, 32'hffffffff);
        wb(0, 8'h0c, 0);
        chk("unmapped", 0, rd);
        wb(1, `RSC_ADDR_STATUS, 32'hffffffff);
        wb(0, `RSC_ADDR_STATUS, 0);
        chk("status ro", cfg, rd[3:0]);
        $display("test registers done");
    endtask
    task automatic t_wdog();
        wb(1, `RSC_ADDR_WDOG, 32'h1);
        repeat (3) @(posedge clk_i);
        chk("wd core", 1, core);
        chk("wd rst", !cfg[2], sro);
        repeat (SYS + 8) @(posedge clk_i);
        chk("wd end", 0, core);
        chk("wd rst off", cfg[2], sro);
        wb(0, `RSC_ADDR_STATUS, 0);
        chk("wd flag", 1, rd[`RSC_ST_WDOG_BIT]);
        $display("test watchdog done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        go <= 1'b0;
        wait_up();
        repeat (8) @(posedge clk_i);
        t_regs();
        t_wdog();
        for (int i = 0; i < 5; i++) t_boot(4'(i * 5 + 1));
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        close_out();
    end
endmodule // reset_strap_clock_control_tb
